// File: logic/fsp_fast_tach_a.sv
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
// Summary of operation
// R01: Bits 7:6 of the spin-up configuration register always read as zero.
// R02: With fast tach set, spin-up drives full duty until timeout, tach ok or a zero command.
// R03: With fast tach set, the spin-up duty field is ignored, drive is full.
// R04: With fast tach clear, spin-up runs the whole interval at set duty unless the command drops to zero.
// R05: A zero spin-up time code skips spin-up even with fast tach set.
// R06: Duty codes 00 skip (unless fast tach), 01 half, 10 ~3/4, 11 full.
// R07: Time codes 1 to 7 give 0.05 s doubling up to 3.2 s.
// R08: Software must also select tach input mode for tach-ended spin-up.
// R09: The PWM value register is read-only while direct program is clear.
// R10: Reads of the PWM value register return zero during spin-up.
// R11: With direct program set, a written PWM value drives the fan output.
// R12: Spin-up starts when the commanded duty goes from zero to nonzero.
module fsp_fast_tach_a #(
    parameter int unsigned BASE_CYCLES = fsp_pkg::SPIN_BASE_CYC
) (
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    // APB slave
    input  wire fsp_pkg::fsp_apb_req_t apb_i,
    output fsp_pkg::fsp_apb_rsp_t      apb_o,
    // Lookup table result and tach comparison
    input  wire logic [7:0]            lut_pwm_value,
    input  wire logic                  tach_rpm_ok,
    // Fan drive
    output logic [7:0]                 fan_pwm_duty,
    output logic                       fast_tach_a_active,
    output logic                       tach_mode_sel
);

    fsp_pkg::fsp_regs_t s_ff;
    fsp_pkg::fsp_regs_t nxt_s;
    logic [7:0]         cmd;
    logic [7:0]         rd_val;
    logic               direct;
    logic               fast;
    logic [1:0]         duty_sel;
    logic [2:0]         time_sel;
    logic               go;
    logic               wr_acc;
    logic               rd_setup;
    logic               acc;

    // 0 none, 1 control, 2 config, 3 pwm value
    function automatic logic [1:0] dec(input logic [11:0] a);
        case (a)
            fsp_pkg::ADDR_CTRL: dec = 2'h1;
            fsp_pkg::ADDR_CFG:  dec = 2'h2;
            fsp_pkg::ADDR_PWM:  dec = 2'h3;
            default:            dec = 2'h0;
        endcase
    endfunction

    function automatic logic [31:0] interval_cyc(input logic [2:0] t);
        interval_cyc = 32'(BASE_CYCLES) << (t - 3'h1);
    endfunction

    function automatic logic [7:0] spin_level(input logic f,
                                              input logic [1:0] d);
        if (f) begin
            spin_level = fsp_pkg::DUTY_FULL;
        end else begin
            case (d)
                2'h1:    spin_level = fsp_pkg::DUTY_HALF;
                2'h2:    spin_level = fsp_pkg::DUTY_THREEQ;
                2'h3:    spin_level = fsp_pkg::DUTY_FULL;
                default: spin_level = 8'h00;
            endcase
        end
    endfunction

    assign direct   = s_ff.ctrl[fsp_pkg::CTRL_DIRECT_BIT];
    assign fast     = s_ff.cfg[fsp_pkg::CFG_FAST_BIT];
    assign duty_sel = s_ff.cfg[fsp_pkg::CFG_DUTY_LSB +: 2];
    assign time_sel = s_ff.cfg[fsp_pkg::CFG_TIME_LSB +: 3];
    assign acc      = apb_i.psel & apb_i.penable;
    assign wr_acc   = acc & apb_i.pwrite;
    assign rd_setup = apb_i.psel & ~apb_i.penable & ~apb_i.pwrite;

    // R11 direct drive
    assign cmd = direct ? s_ff.pwm_wr : lut_pwm_value;

    // R05 zero time skips
    // R06 duty 00 skips
    assign go = (time_sel != 3'h0) & (fast | (duty_sel != 2'h0));

    always_comb begin
        case (dec(apb_i.paddr))
            2'h1:    rd_val = s_ff.ctrl & fsp_pkg::CTRL_WMASK;
            // R01 reserved read zero
            2'h2:    rd_val = {2'h0, s_ff.cfg[5:0]};
            // R10 zero in spin-up
            2'h3:    rd_val = (s_ff.st == fsp_pkg::ST_SPIN) ? 8'h00 : cmd;
            default: rd_val = 8'h00;
        endcase
    end

    always_comb begin
        nxt_s = s_ff;
        if (wr_acc && dec(apb_i.paddr) == 2'h1) begin
            nxt_s.ctrl = apb_i.pwdata[7:0] & fsp_pkg::CTRL_WMASK;
        end
        if (wr_acc && dec(apb_i.paddr) == 2'h2) begin
            nxt_s.cfg = apb_i.pwdata[7:0] & fsp_pkg::CFG_WMASK;
        end
        // R09 write only when direct
        if (wr_acc && dec(apb_i.paddr) == 2'h3 && direct) begin
            nxt_s.pwm_wr = apb_i.pwdata[7:0];
        end
        // Data latched in setup so the answer is a flop
        if (rd_setup) begin
            nxt_s.rdata = {24'h0, rd_val};
        end
        nxt_s.prev_zero = (cmd == 8'h00);
        case (s_ff.st)
            fsp_pkg::ST_IDLE: begin
                // R12 start on zero to nonzero
                if (s_ff.prev_zero && cmd != 8'h00 && go) begin
                    nxt_s.st  = fsp_pkg::ST_SPIN;
                    // R07 interval length
                    nxt_s.cnt = interval_cyc(time_sel);
                end
            end
            fsp_pkg::ST_SPIN: begin
                // R02 tach ends early
                // R04 without fast tach only a zero command ends it early
                if ((fast && tach_rpm_ok) || s_ff.cnt <= 32'h1
                    || cmd == 8'h00) begin
                    nxt_s.st  = fsp_pkg::ST_IDLE;
                    nxt_s.cnt = 32'h0;
                end else begin
                    nxt_s.cnt = s_ff.cnt - 32'h1;
                end
            end
            default: begin
                nxt_s.st = fsp_pkg::ST_IDLE;
            end
        endcase
        // R03 fast tach forces full
        nxt_s.duty = (s_ff.st == fsp_pkg::ST_SPIN)
                     ? spin_level(fast, duty_sel) : cmd;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_ff.st        <= fsp_pkg::ST_IDLE;
            s_ff.cnt       <= 32'h0;
            s_ff.ctrl      <= fsp_pkg::CTRL_RST;
            s_ff.cfg       <= fsp_pkg::CFG_RST;
            s_ff.pwm_wr    <= fsp_pkg::PWM_RST;
            s_ff.prev_zero <= 1'b1;
            s_ff.duty      <= 8'h00;
            s_ff.rdata     <= 32'h0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // Zero wait states; unmapped addresses answer with an error
    assign apb_o.pready  = acc;
    assign apb_o.pslverr = acc & (dec(apb_i.paddr) == 2'h0);
    assign apb_o.prdata  = s_ff.rdata;

    assign fan_pwm_duty  = s_ff.duty;
    assign fast_tach_a_active = (s_ff.st == fsp_pkg::ST_SPIN);
    // R08 tach mode handed out
    assign tach_mode_sel = s_ff.ctrl[fsp_pkg::CTRL_TACH_BIT];

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence rd_cfg_seq;
        rd_setup && dec(apb_i.paddr) == 2'h2 ##1 acc;
    endsequence

    sequence rd_pwm_spin_seq;
        rd_setup && dec(apb_i.paddr) == 2'h3 && fast_tach_a_active ##1 acc;
    endsequence

    sequence start_seq;
        !fast_tach_a_active && s_ff.prev_zero && cmd != 8'h00;
    endsequence

    // Table read answers with the value seen at setup
    sequence rd_pwm_table_seq;
        rd_setup && dec(apb_i.paddr) == 2'h3 && !fast_tach_a_active && !direct
        ##1 acc;
    endsequence

    a_rsvd_read_zero: assert property ( // R01
        rd_cfg_seq |-> apb_o.prdata[7:6] == 2'h0)
        else $error("Reserved config bits read nonzero");

    a_fast_full_duty: assert property ( // R03
        $past(fast_tach_a_active && fast) |-> fan_pwm_duty == fsp_pkg::DUTY_FULL)
        else $error("Fast spin-up not at full duty");

    a_tach_early_end: assert property ( // R02
        fast_tach_a_active && fast && tach_rpm_ok |=> !fast_tach_a_active)
        else $error("Tach did not end fast spin-up");

    a_no_tach_end: assert property ( // R04
        fast_tach_a_active && !fast && s_ff.cnt > 32'h1 && cmd != 8'h00
        |=> fast_tach_a_active)
        else $error("Spin-up ended early without fast tach");

    a_zero_time_skip: assert property ( // R05
        start_seq and (time_sel == 3'h0) |=> !fast_tach_a_active)
        else $error("Spin-up ran with zero time code");

    a_half_duty_code: assert property ( // R06
        fast_tach_a_active && !fast && duty_sel == 2'h1
        |=> fan_pwm_duty == fsp_pkg::DUTY_HALF)
        else $error("Duty code 01 not half");

    a_interval_load: assert property ( // R07
        $rose(fast_tach_a_active) |-> s_ff.cnt == interval_cyc($past(time_sel)))
        else $error("Spin-up interval loaded wrong");

    a_pwm_read_only: assert property ( // R09
        wr_acc && dec(apb_i.paddr) == 2'h3 && !direct
        |=> $stable(s_ff.pwm_wr))
        else $error("PWM value written while read-only");

    a_spin_read_zero: assert property ( // R10
        rd_pwm_spin_seq |-> apb_o.prdata == 32'h0)
        else $error("PWM value read nonzero in spin-up");

    a_direct_drive: assert property ( // R11
        direct && !fast_tach_a_active && !$past(fast_tach_a_active)
        |=> fan_pwm_duty == $past(s_ff.pwm_wr))
        else $error("Direct value not driven");

    a_spin_start: assert property ( // R12
        start_seq and go |=> fast_tach_a_active)
        else $error("Spin-up did not start");

    a_three_q_code: assert property ( // R06
        fast_tach_a_active && !fast && duty_sel == 2'h2
        |=> fan_pwm_duty == fsp_pkg::DUTY_THREEQ)
        else $error("Duty code 10 not three quarters");

    a_full_code: assert property ( // R06
        fast_tach_a_active && !fast && duty_sel == 2'h3
        |=> fan_pwm_duty == fsp_pkg::DUTY_FULL)
        else $error("Duty code 11 not full");

    a_zero_duty_skip: assert property ( // R06
        start_seq and (!fast && duty_sel == 2'h0) |=> !fast_tach_a_active)
        else $error("Spin-up ran with duty code 00");

    a_fast_zero_code: assert property ( // R03
        fast_tach_a_active && fast && duty_sel == 2'h0
        |=> fan_pwm_duty == fsp_pkg::DUTY_FULL)
        else $error("Fast spin-up used duty code 00");

    a_fast_half_code: assert property ( // R03
        fast_tach_a_active && fast && duty_sel == 2'h1
        |=> fan_pwm_duty == fsp_pkg::DUTY_FULL)
        else $error("Fast spin-up used duty code 01");

    a_interval_end: assert property ( // R02
        fast_tach_a_active && s_ff.cnt <= 32'h1 |=> !fast_tach_a_active)
        else $error("Spin-up outlived its interval");

    a_interval_step: assert property ( // R07
        fast_tach_a_active && s_ff.cnt > 32'h1 && !(fast && tach_rpm_ok)
        && cmd != 8'h00 |=> s_ff.cnt == $past(s_ff.cnt) - 32'h1)
        else $error("Spin-up counter did not step");

    a_tach_ignored: assert property ( // R04
        fast_tach_a_active && !fast && tach_rpm_ok && s_ff.cnt > 32'h1
        && cmd != 8'h00 |=> fast_tach_a_active)
        else $error("Tach ended spin-up without fast tach");

    a_zero_time_idle: assert property ( // R05
        time_sel == 3'h0 && !fast_tach_a_active |=> !fast_tach_a_active)
        else $error("Spin-up began with zero time code");

    a_cfg_write_mask: assert property ( // R01
        wr_acc && dec(apb_i.paddr) == 2'h2 |=> s_ff.cfg[7:6] == 2'h0)
        else $error("Reserved config bits stored");

    a_cfg_read_value: assert property ( // R01
        rd_cfg_seq |-> apb_o.prdata == {26'h0, $past(s_ff.cfg[5:0])})
        else $error("Config read value wrong");

    a_pwm_write_direct: assert property ( // R11
        wr_acc && dec(apb_i.paddr) == 2'h3 && direct
        |=> s_ff.pwm_wr == $past(apb_i.pwdata[7:0]))
        else $error("Direct PWM value not stored");

    a_table_drive: assert property ( // R09
        !direct && !fast_tach_a_active |=> fan_pwm_duty == $past(lut_pwm_value))
        else $error("Table value not driven while read-only");

    a_table_read: assert property ( // R09
        rd_pwm_table_seq |-> apb_o.prdata == {24'h0, $past(lut_pwm_value)})
        else $error("PWM value read differs from table");

    a_abort_on_zero: assert property ( // R12
        fast_tach_a_active && cmd == 8'h00 |=> !fast_tach_a_active)
        else $error("Spin-up kept running at zero command");

    a_resume_normal: assert property ( // R12
        $fell(fast_tach_a_active) |=> fan_pwm_duty == $past(cmd))
        else $error("Normal drive did not resume");

endmodule

// File: logic/fsp_pkg.sv
package fsp_pkg;

    // Register indexes; byte address is four times the index
    localparam logic [7:0]  IDX_CTRL       = 8'h4A;
    localparam logic [7:0]  IDX_CFG        = 8'h4B;
    localparam logic [7:0]  IDX_PWM        = 8'h4C;
    localparam logic [11:0] ADDR_CTRL      = {2'h0, IDX_CTRL, 2'h0};
    localparam logic [11:0] ADDR_CFG       = {2'h0, IDX_CFG, 2'h0};
    localparam logic [11:0] ADDR_PWM       = {2'h0, IDX_PWM, 2'h0};

    // Field positions
    localparam int          CTRL_DIRECT_BIT = 5;
    localparam int          CTRL_TACH_BIT   = 2;
    localparam int          CFG_FAST_BIT    = 5;
    localparam int          CFG_DUTY_LSB    = 3;
    localparam int          CFG_TIME_LSB    = 0;
    localparam logic [7:0]  CTRL_WMASK      = 8'h3F;
    localparam logic [7:0]  CFG_WMASK       = 8'h3F;

    // Reset values
    localparam logic [7:0]  CTRL_RST        = 8'h20;
    localparam logic [7:0]  CFG_RST         = 8'h3F;
    localparam logic [7:0]  PWM_RST         = 8'h00;

    // Spin-up drive levels
    localparam logic [7:0]  DUTY_FULL       = 8'hFF;
    localparam logic [7:0]  DUTY_HALF       = 8'h80;
    localparam logic [7:0]  DUTY_THREEQ     = 8'hC0;

    // Timing: shortest spin-up interval, doubled per code step
    localparam longint unsigned SPIN_BASE_NS = 64'h0000_0000_02FA_F080;
    localparam longint unsigned CLK_MHZ      = 64'h0000_0000_0000_00FA;
    localparam int unsigned SPIN_BASE_CYC    =
        int'(SPIN_BASE_NS * CLK_MHZ / 64'h0000_0000_0000_03E8);

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_SPIN = 1'b1
    } fsp_state_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } fsp_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } fsp_apb_rsp_t;

    typedef struct packed {
        fsp_state_t  st;
        logic [31:0] cnt;
        logic [7:0]  ctrl;
        logic [7:0]  cfg;
        logic [7:0]  pwm_wr;
        logic        prev_zero;
        logic [7:0]  duty;
        logic [31:0] rdata;
    } fsp_regs_t;

endpackage

// File: tb/fsp_fan_model.sv
`timescale 1ns/1ps
module fsp_fan_model (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst,
    // Drive from the block
    input  wire logic [7:0] fan_pwm_duty,
    input  wire logic       tach_mode_sel,
    // Cycles of drive until the fan is up to speed
    input  wire logic [7:0] spin_delay,
    // Speed comparison
    output logic            tach_rpm_ok
);
    logic [7:0] run_ff;

    // Fan coasts down at once when drive stops
    always_ff @(posedge sys_clk) begin
        if (rst || fan_pwm_duty == 8'h00)
            run_ff <= 8'h00;
        else if (run_ff != 8'hFF)
            run_ff <= run_ff + 8'h01;
    end

    assign tach_rpm_ok = tach_mode_sel && run_ff >= spin_delay;
endmodule

// File: tb/fan_fast_tach_a_pwm_control_test.sv
`timescale 1ns/1ps
module fan_fast_tach_a_pwm_control_test;
    logic                  sys_clk;
    logic                  rst;
    fsp_pkg::fsp_apb_req_t req;
    fsp_pkg::fsp_apb_rsp_t rsp;
    logic [7:0]            lut;
    logic                  tach_ok;
    logic [7:0]            duty;
    logic                  spin_act;
    logic                  tach_sel;
    logic [7:0]            delay;
    logic [7:0]            spin_duty;
    logic                  was_act;
    logic                  last_err;
    int                    act_cnt;
    int                    c0;
    int                    failures;
    int                    compares;

    fsp_fast_tach_a #(.BASE_CYCLES(4)) dut (
        .sys_clk       (sys_clk),
        .rst           (rst),
        .apb_i         (req),
        .apb_o         (rsp),
        .lut_pwm_value (lut),
        .tach_rpm_ok   (tach_ok),
        .fan_pwm_duty  (duty),
        .fast_tach_a_active (spin_act),
        .tach_mode_sel (tach_sel)
    );

    fsp_fan_model fan (
        .sys_clk       (sys_clk),
        .rst           (rst),
        .fan_pwm_duty  (duty),
        .tach_mode_sel (tach_sel),
        .spin_delay    (delay),
        .tach_rpm_ok   (tach_ok)
    );

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // Drive lags state by one cycle, so take the level on the second
    always @(posedge sys_clk) begin
        if (spin_act)
            act_cnt <= act_cnt + 1;
        if (spin_act && was_act)
            spin_duty <= duty;
        was_act <= spin_act;
    end

    task automatic end_of_test();
        $display("failures=%0d compares=%0d", failures, compares);
        if (failures == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        @(posedge sys_clk);
        req <= '{1'b1, 1'b0, wr, a, {24'h0, d}};
        @(posedge sys_clk);
        req.penable <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do begin
            @(posedge sys_clk);
        end while (rsp.pready !== 1'b1);
        q = rsp.prdata[7:0];
        last_err = rsp.pslverr;
        req <= '0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [7:0] q;
        apb(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        logic [7:0] q;
        apb(1'b0, a, 8'h00, q);
        chk({24'h0, q}, {24'h0, exp});
    endtask

    // Negative length: must end early on tach, before the full interval
    task automatic spin(input logic [7:0] cfg, input logic [7:0] lvl,
                        input int len);
        int s;
        wr(fsp_pkg::ADDR_PWM, 8'h00);
        wr(fsp_pkg::ADDR_CFG, cfg);
        s = act_cnt;
        wr(fsp_pkg::ADDR_PWM, 8'h40);
        repeat (3) @(posedge sys_clk);
        if (len > 8 || len < 0)
            rd(fsp_pkg::ADDR_PWM, 8'h00);
        for (int n = 0; n < 400 && spin_act !== 1'b0; n++)
            @(posedge sys_clk);
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        if (len < 0)
            chk({31'h0, act_cnt - s > 0 && act_cnt - s < 256}, 32'h1);
        else
            chk(act_cnt - s, len);
        if (len != 0)
            chk({24'h0, spin_duty}, {24'h0, lvl});
        chk({24'h0, duty}, 32'h40);
    endtask

    initial begin
        req = '0;
        lut = 8'h00;
        delay = 8'h02;
        rst = 1'b1;
        act_cnt = 0;
        was_act = 1'b0;
        spin_duty = 8'h00;
        last_err = 1'b0;
        failures = 0;
        compares = 0;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        rd(fsp_pkg::ADDR_CTRL, 8'h20);
        rd(fsp_pkg::ADDR_CFG, 8'h3F);
        rd(fsp_pkg::ADDR_PWM, 8'h00);
        wr(fsp_pkg::ADDR_CFG, 8'hFF);
        rd(fsp_pkg::ADDR_CFG, 8'h3F);
        rd(12'h200, 8'h00);
        chk({31'h0, last_err}, 32'h1);
        wr(fsp_pkg::ADDR_CTRL, 8'h24);
        for (int k = 1; k < 8; k++)
            spin(8'h18 | 8'(k), 8'hFF, 4 << (k - 1));
        spin(8'h01, 8'h00, 0);
        spin(8'h09, 8'h80, 4);
        spin(8'h11, 8'hC0, 4);
        spin(8'h38, 8'hFF, 0);
        delay <= 8'h14;
        spin(8'h2F, 8'hFF, -1);
        spin(8'h21, 8'hFF, 4);
        c0 = act_cnt;
        wr(fsp_pkg::ADDR_PWM, 8'h60);
        repeat (8) @(posedge sys_clk);
        @(negedge sys_clk);
        chk(act_cnt - c0, 0);
        // Time code zero keeps the table value from spinning up
        wr(fsp_pkg::ADDR_CFG, 8'h00);
        lut <= 8'h33;
        wr(fsp_pkg::ADDR_CTRL, 8'h04);
        wr(fsp_pkg::ADDR_PWM, 8'h77);
        rd(fsp_pkg::ADDR_PWM, 8'h33);
        @(negedge sys_clk);
        chk({24'h0, duty}, 32'h33);
        wr(fsp_pkg::ADDR_CTRL, 8'h24);
        wr(fsp_pkg::ADDR_PWM, 8'h55);
        rd(fsp_pkg::ADDR_PWM, 8'h55);
        @(negedge sys_clk);
        chk({24'h0, duty}, 32'h55);
        end_of_test();
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        end_of_test();
    end
endmodule
